// ==== shared/mdma_pkg.sv ====
// Purpose: constants and types shared by the multichannel dma controller
// Assumes: byte addresses on the register bus, 32-bit data words
// Notes:   channel registers sit in 0x80-byte windows after the crc block
package mdma_pkg;
    // widths
    localparam int AW  = 16;
    localparam int CHW = 3;
    localparam int NEV = 7;

    // global register byte addresses
    localparam logic [15:0] A_GCTRL  = 16'h1000;
    localparam logic [15:0] A_GSTAT  = 16'h1010;
    localparam logic [15:0] A_EADDR  = 16'h1020;
    localparam logic [15:0] A_CRCCTL = 16'h1030;
    localparam logic [15:0] A_CRCDAT = 16'h1040;
    localparam logic [15:0] A_CRCPOL = 16'h1050;
    localparam logic [15:0] A_CHBASE = 16'h1060;
    localparam logic [15:0] A_CHEND  = 16'h1460;
    // clear, set and invert aliases
    localparam logic [15:0] A_CLR    = 16'h0004;
    localparam logic [15:0] A_SET    = 16'h0008;
    localparam logic [15:0] A_INV    = 16'h000c;

    // channel window decode
    localparam int          CH_LSB   = 7;
    localparam int          RG_LSB   = 4;
    localparam logic [2:0]  R_CTRL   = 3'h0;
    localparam logic [2:0]  R_SRC    = 3'h1;
    localparam logic [2:0]  R_DST    = 3'h2;
    localparam logic [2:0]  R_SIZE   = 3'h3;
    localparam logic [2:0]  R_EVT    = 3'h4;
    localparam logic [2:0]  R_MASK   = 3'h5;

    // global control and status fields
    localparam int          GC_ON    = 15;
    localparam int          GC_SUSP  = 12;
    localparam int          GC_BUSY  = 11;
    localparam logic [31:0] GC_WMASK = 32'h00009000;
    localparam int          GS_LAST_ERROR_DIRECTION  = 31;

    // channel control fields
    localparam int          C_EN     = 0;
    localparam int          C_AUTO   = 1;
    localparam int          C_CHAIN  = 2;
    localparam int          C_PATEN  = 3;
    localparam int          C_PAT2   = 4;
    localparam int          C_SIEN   = 5;
    localparam int          C_AIEN   = 6;
    localparam int          C_FORCE  = 7;
    localparam logic [31:0] C_WMASK  = 32'h00ffff7f;

    // channel event bits
    localparam int          E_BLK    = 0;
    localparam int          E_SEMP   = 1;
    localparam int          E_SHALF  = 2;
    localparam int          E_DFULL  = 3;
    localparam int          E_DHALF  = 4;
    localparam int          E_ABT    = 5;
    localparam int          E_ADR    = 6;

    // crc control fields
    localparam int          CRC_EN   = 7;

    // bus answer
    localparam logic [1:0]  RESP_OK  = 2'b00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD   = 2'b01,
        ST_WR   = 2'b10
    } mdma_state_t;
endpackage

// ==== logic/mdma_top.sv ====
// Purpose: multichannel dma controller, avalon slave for registers,
//          avalon master for data
// Assumes: at most 8 channels, peripheral interrupt lines synchronous
// Notes:   one byte moved per grant, channels re-arbitrated between bytes
// Behaviour
// - The engine masters the data bus and moves bytes between any two addresses alone.
// - Each channel keeps source and destination pointers that step on as bytes move.
// - Every access moves one byte and its single byte enable lane is picked from the address.
// - Any byte alignment is accepted at both source and destination.
// - Among pending channels the bus goes out by a fixed priority order.
// - A channel starts on a forced software request or on a chosen interrupt event.
// - A channel stops after one block or stays enabled for its next start, and can be chained from the previous one.
// - The start trigger of each channel selects any peripheral interrupt line.
// - An abort trigger per channel selects any interrupt line and ends the transfer.
// - A block can end early when moved data matches a one or two byte pattern.
// - Block done, source empty and half, dest full and half, abort and bad address raise events.
// - The address of the latest failing access is kept in a 32-bit register.
// - The number of the channel that last moved data is kept in a three bit field.
// - One configurable crc unit can be attached to any one channel.
// - The global control register has clear, set and invert aliases at plus 4, 8 and c.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module mdma_top #(
    parameter int NCH  = 8,
    parameter int NIRQ = 256
) (
    // clock and reset
    input  wire logic                    I_CLK,
    input  wire logic                    I_RST,
    // register slave
    input  wire logic [mdma_pkg::AW-1:0] I_S_ADDRESS,
    input  wire logic                    I_S_READ,
    input  wire logic                    I_S_WRITE,
    input  wire logic [31:0]             I_S_WRITEDATA,
    input  wire logic [3:0]              I_S_BYTEENABLE,
    output logic      [31:0]             O_S_READDATA,
    output logic                         O_S_WAITREQUEST,
    // data master
    output logic      [31:0]             O_M_ADDRESS,
    output logic                         O_M_READ,
    output logic                         O_M_WRITE,
    output logic      [31:0]             O_M_WRITEDATA,
    output logic      [3:0]              O_M_BYTEENABLE,
    input  wire logic                    I_M_WAITREQUEST,
    input  wire logic [31:0]             I_M_READDATA,
    input  wire logic [1:0]              I_M_RESPONSE,
    // peripheral interrupts in, controller interrupt out
    input  wire logic [NIRQ-1:0]         I_IRQ,
    output logic                         O_IRQ
);
    import mdma_pkg::*;

    // crc step over one byte, msb first
    function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d,
                                            input logic [31:0] p);
        logic [31:0] r;
        logic        fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = r[31] ^ d[i];
            r  = {r[30:0], 1'b0} ^ (fb ? p : 32'h0);
        end
        return r;
    endfunction

    // bus slave state
    logic              ack_ff, nxt_ack;
    logic [31:0]       rdata_ff, nxt_rdata;
    logic [31:0]       rmux, bm, wdm, gword;
    logic              wr_acc, rd_acc, ch_hit;
    logic [15:0]       ch_off;
    logic [CHW-1:0]    ch_idx;
    logic [2:0]        ch_reg;
    // global state
    logic [31:0]       gctrl_ff, nxt_gctrl, eaddr_ff, nxt_eaddr;
    logic [CHW-1:0]    lastch_ff, nxt_lastch;
    logic              last_error_direction_ff, nxt_last_error_direction;
    logic [31:0]       crcctl_ff, nxt_crcctl, crcdat_ff, nxt_crcdat, crcpol_ff, nxt_crcpol;
    logic [NIRQ-1:0]   irq_q_ff, irq_rise;
    // engine state
    mdma_state_t       st_ff, nxt_st;
    logic [CHW-1:0]    cur_ff, nxt_cur, win;
    logic [31:0]       addr_ff, nxt_addr;
    logic [7:0]        byte_ff, nxt_byte;
    logic              eng_rd_ok, eng_wr_ok, eng_err, busy, go;
    // per channel views
    wire  [31:0]       ch_src [NCH];
    wire  [31:0]       ch_dst [NCH];
    wire  [31:0]       ch_rd  [NCH];
    wire  [NCH-1:0]    ch_pend, blk_done, ch_irq, chain_in;

    // slave decode and strobes
    assign wr_acc          = I_S_WRITE & ack_ff;
    assign rd_acc          = I_S_READ & ack_ff;
    assign O_S_WAITREQUEST = (I_S_READ | I_S_WRITE) & ~ack_ff;
    assign O_S_READDATA    = rdata_ff;
    assign bm     = {{8{I_S_BYTEENABLE[3]}}, {8{I_S_BYTEENABLE[2]}},
                     {8{I_S_BYTEENABLE[1]}}, {8{I_S_BYTEENABLE[0]}}};
    assign wdm    = I_S_WRITEDATA & bm;
    assign ch_off = I_S_ADDRESS - A_CHBASE;
    assign ch_idx = ch_off[CH_LSB +: CHW];
    assign ch_reg = ch_off[RG_LSB +: 3];
    assign ch_hit = (I_S_ADDRESS >= A_CHBASE) && (I_S_ADDRESS < A_CHEND)
                    && (ch_off[3:0] == 4'h0) && (ch_reg <= R_MASK)
                    && (int'(ch_idx) < NCH);

    // read mux, unmapped reads return zero
    always_comb begin
        gword          = gctrl_ff;
        gword[GC_BUSY] = busy;
        case (I_S_ADDRESS)
            A_GCTRL:  rmux = gword;
            A_GSTAT:  rmux = {last_error_direction_ff, 28'h0, lastch_ff};
            A_EADDR:  rmux = eaddr_ff;
            A_CRCCTL: rmux = crcctl_ff;
            A_CRCDAT: rmux = crcdat_ff;
            A_CRCPOL: rmux = crcpol_ff;
            default:  rmux = ch_hit ? ch_rd[ch_idx] : 32'h0;
        endcase
    end

    // slave handshake: answer in the second cycle of each request
    always_comb begin
        nxt_ack   = (I_S_READ | I_S_WRITE) & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (I_S_READ & ~ack_ff) begin
            nxt_rdata = rmux;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    // global registers, error capture, crc
    assign irq_rise = I_IRQ & ~irq_q_ff;
    always_comb begin
        nxt_gctrl  = gctrl_ff;
        nxt_eaddr  = eaddr_ff;
        nxt_lastch = lastch_ff;
        nxt_last_error_direction   = last_error_direction_ff;
        nxt_crcctl = crcctl_ff;
        nxt_crcdat = crcdat_ff;
        nxt_crcpol = crcpol_ff;
        if (eng_wr_ok) begin
            nxt_lastch = cur_ff;
        end
        if (eng_err) begin
            nxt_eaddr = addr_ff;
            nxt_last_error_direction  = (st_ff == ST_RD);
        end
        if (eng_wr_ok && crcctl_ff[CRC_EN] && (crcctl_ff[CHW-1:0] == cur_ff)) begin
            nxt_crcdat = crc_upd(crcdat_ff, byte_ff, crcpol_ff);
        end
        if (wr_acc) begin
            case (I_S_ADDRESS)
                A_GCTRL:         nxt_gctrl = (gctrl_ff & ~(bm & GC_WMASK)) | (wdm & GC_WMASK);
                A_GCTRL | A_CLR: nxt_gctrl = gctrl_ff & ~(wdm & GC_WMASK);
                A_GCTRL | A_SET: nxt_gctrl = gctrl_ff | (wdm & GC_WMASK);
                A_GCTRL | A_INV: nxt_gctrl = gctrl_ff ^ (wdm & GC_WMASK);
                A_CRCCTL:        nxt_crcctl = (crcctl_ff & ~bm) | wdm;
                A_CRCDAT:        nxt_crcdat = (crcdat_ff & ~bm) | wdm;
                A_CRCPOL:        nxt_crcpol = (crcpol_ff & ~bm) | wdm;
                default:         nxt_gctrl = gctrl_ff;
            endcase
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            gctrl_ff  <= 32'h0;
            eaddr_ff  <= 32'h0;
            lastch_ff <= '0;
            last_error_direction_ff   <= 1'b0;
            crcctl_ff <= 32'h0;
            crcdat_ff <= 32'h0;
            crcpol_ff <= 32'h0;
            irq_q_ff  <= '0;
        end else begin
            gctrl_ff  <= nxt_gctrl;
            eaddr_ff  <= nxt_eaddr;
            lastch_ff <= nxt_lastch;
            last_error_direction_ff   <= nxt_last_error_direction;
            crcctl_ff <= nxt_crcctl;
            crcdat_ff <= nxt_crcdat;
            crcpol_ff <= nxt_crcpol;
            irq_q_ff  <= I_IRQ;
        end
    end

    // engine strobes and master outputs
    assign busy           = (st_ff != ST_IDLE);
    assign eng_rd_ok      = (st_ff == ST_RD) & ~I_M_WAITREQUEST & (I_M_RESPONSE == RESP_OK);
    assign eng_wr_ok      = (st_ff == ST_WR) & ~I_M_WAITREQUEST & (I_M_RESPONSE == RESP_OK);
    assign eng_err        = busy & ~I_M_WAITREQUEST & (I_M_RESPONSE != RESP_OK);
    assign O_M_ADDRESS    = {addr_ff[31:2], 2'b00};
    assign O_M_BYTEENABLE = 4'h1 << addr_ff[1:0];
    assign O_M_READ       = (st_ff == ST_RD);
    assign O_M_WRITE      = (st_ff == ST_WR);
    assign O_M_WRITEDATA  = {4{byte_ff}};
    assign chain_in       = {blk_done[NCH-2:0], 1'b0};
    assign O_IRQ          = |ch_irq;
    assign go             = gctrl_ff[GC_ON] & ~gctrl_ff[GC_SUSP] & (|ch_pend);

    // fixed priority pick and byte move sequence
    always_comb begin
        win = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (ch_pend[i]) begin
                win = CHW'(i);
            end
        end
        nxt_st   = st_ff;
        nxt_cur  = cur_ff;
        nxt_addr = addr_ff;
        nxt_byte = byte_ff;
        case (st_ff)
            ST_IDLE: begin
                if (go) begin
                    nxt_cur  = win;
                    nxt_addr = ch_src[win];
                    nxt_st   = ST_RD;
                end
            end
            ST_RD: begin
                if (eng_err) begin
                    nxt_st = ST_IDLE;
                end else if (eng_rd_ok) begin
                    nxt_byte = 8'(I_M_READDATA >> {addr_ff[1:0], 3'b000});
                    nxt_addr = ch_dst[cur_ff];
                    nxt_st   = ST_WR;
                end
            end
            ST_WR: begin
                if (eng_err || eng_wr_ok) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            st_ff   <= ST_IDLE;
            cur_ff  <= '0;
            addr_ff <= 32'h0;
            byte_ff <= 8'h0;
        end else begin
            st_ff   <= nxt_st;
            cur_ff  <= nxt_cur;
            addr_ff <= nxt_addr;
            byte_ff <= nxt_byte;
        end
    end

    // per channel registers, triggers and events
    for (genvar g = 0; g < NCH; g++) begin : gch
        logic [31:0]    ctrl_ff, nxt_ctrl, src_ff, nxt_src, dst_ff, nxt_dst;
        logic [31:0]    size_ff, nxt_size, rd_w;
        logic [NEV-1:0] evt_ff, nxt_evt, mask_ff, nxt_mask, ev;
        logic [15:0]    cnt_ff, nxt_cnt, cnt1;
        logic [7:0]     prev_ff, nxt_prev;
        logic           pend_ff, nxt_pend, abt_ff, nxt_abt, mine, wsel, done, hit, start;

        always_comb begin
            mine     = (cur_ff == CHW'(g)) & busy;
            wsel     = wr_acc & ch_hit & (ch_idx == CHW'(g));
            cnt1     = cnt_ff + 16'h1;
            hit      = ctrl_ff[C_PAT2] ? ({prev_ff, byte_ff} == size_ff[31:16])
                                       : (byte_ff == size_ff[23:16]);
            nxt_ctrl = ctrl_ff;
            nxt_src  = src_ff;
            nxt_dst  = dst_ff;
            nxt_size = size_ff;
            nxt_mask = mask_ff;
            nxt_cnt  = cnt_ff;
            nxt_prev = prev_ff;
            nxt_pend = pend_ff;
            nxt_abt  = abt_ff;
            ev       = '0;
            done     = 1'b0;
            if (wsel) begin
                case (ch_reg)
                    R_CTRL:  nxt_ctrl = (ctrl_ff & ~(bm & C_WMASK)) | (wdm & C_WMASK);
                    R_SRC:   nxt_src  = (src_ff & ~bm) | wdm;
                    R_DST:   nxt_dst  = (dst_ff & ~bm) | wdm;
                    R_SIZE:  nxt_size = (size_ff & ~bm) | wdm;
                    R_MASK:  nxt_mask = NEV'((mask_ff & ~bm[NEV-1:0]) | wdm[NEV-1:0]);
                    default: nxt_mask = mask_ff;
                endcase
            end
            start = (ctrl_ff[C_SIEN] & irq_rise[ctrl_ff[15:8]])
                  | (wsel & (ch_reg == R_CTRL) & wdm[C_FORCE])
                  | (ctrl_ff[C_CHAIN] & chain_in[g]);
            if (start & ctrl_ff[C_EN]) begin
                nxt_pend = 1'b1;
            end
            if (mine & eng_rd_ok) begin
                ev[E_SEMP]  = (cnt1 == size_ff[15:0]);
                ev[E_SHALF] = (cnt1 == {1'b0, size_ff[15:1]});
            end
            if (mine & eng_wr_ok) begin
                nxt_prev    = byte_ff;
                nxt_cnt     = cnt1;
                ev[E_DHALF] = (cnt1 == {1'b0, size_ff[15:1]});
                ev[E_DFULL] = (cnt1 == size_ff[15:0]);
                if ((cnt1 == size_ff[15:0]) || (ctrl_ff[C_PATEN] & hit)) begin
                    done      = 1'b1;
                    ev[E_BLK] = 1'b1;
                    nxt_cnt   = 16'h0;
                    nxt_pend  = 1'b0;
                    if (!ctrl_ff[C_AUTO]) begin
                        nxt_ctrl[C_EN] = 1'b0;
                    end
                end
            end
            if (mine & eng_err) begin
                ev[E_ADR]      = 1'b1;
                nxt_cnt        = 16'h0;
                nxt_pend       = 1'b0;
                nxt_ctrl[C_EN] = 1'b0;
            end
            if (ctrl_ff[C_AIEN] & irq_rise[ctrl_ff[23:16]] & (pend_ff | mine)) begin
                nxt_abt = 1'b1;
            end
            if (abt_ff & ~mine) begin
                ev[E_ABT] = 1'b1;
                nxt_abt   = 1'b0;
                nxt_pend  = 1'b0;
                nxt_cnt   = 16'h0;
            end
            // read clears only what the reader saw, new events still land
            nxt_evt = (evt_ff & ~((rd_acc & ch_hit & (ch_idx == CHW'(g)) & (ch_reg == R_EVT))
                                  ? rdata_ff[NEV-1:0] : '0)) | ev;
            case (ch_reg)
                R_CTRL:  rd_w = ctrl_ff;
                R_SRC:   rd_w = src_ff;
                R_DST:   rd_w = dst_ff;
                R_SIZE:  rd_w = size_ff;
                R_EVT:   rd_w = {25'h0, evt_ff};
                R_MASK:  rd_w = {25'h0, mask_ff};
                default: rd_w = 32'h0;
            endcase
        end

        always_ff @(posedge I_CLK or posedge I_RST) begin
            if (I_RST) begin
                ctrl_ff <= 32'h0;
                src_ff  <= 32'h0;
                dst_ff  <= 32'h0;
                size_ff <= 32'h0;
                evt_ff  <= '0;
                mask_ff <= '0;
                cnt_ff  <= 16'h0;
                prev_ff <= 8'h0;
                pend_ff <= 1'b0;
                abt_ff  <= 1'b0;
            end else begin
                ctrl_ff <= nxt_ctrl;
                src_ff  <= nxt_src;
                dst_ff  <= nxt_dst;
                size_ff <= nxt_size;
                evt_ff  <= nxt_evt;
                mask_ff <= nxt_mask;
                cnt_ff  <= nxt_cnt;
                prev_ff <= nxt_prev;
                pend_ff <= nxt_pend;
                abt_ff  <= nxt_abt;
            end
        end

        // channel views for engine, read mux and interrupt
        assign ch_src[g]   = src_ff + {16'h0, cnt_ff};
        assign ch_dst[g]   = dst_ff + {16'h0, cnt_ff};
        assign ch_rd[g]    = rd_w;
        assign ch_pend[g]  = pend_ff & ctrl_ff[C_EN] & ~abt_ff;
        assign blk_done[g] = done;
        assign ch_irq[g]   = |(evt_ff & mask_ff);
    end
endmodule // mdma_top

// ==== tb/mdma_top_asserts.sv ====
// Purpose: port assertions for the dma controller
// Assumes: one clock, async active high reset
// Notes:   bound to the top from the bench file
`timescale 1ns/1ps
module mdma_top_asserts
    import mdma_pkg::*;
(
    // clock, reset and register slave
    input wire logic        I_CLK,
    input wire logic        I_RST,
    input wire logic        I_S_READ,
    input wire logic        I_S_WRITE,
    input wire logic        O_S_WAITREQUEST,
    // data master
    input wire logic [31:0] O_M_ADDRESS,
    input wire logic        O_M_READ,
    input wire logic        O_M_WRITE,
    input wire logic [31:0] O_M_WRITEDATA,
    input wire logic [3:0]  O_M_BYTEENABLE,
    input wire logic        I_M_WAITREQUEST,
    input wire logic [31:0] I_M_READDATA,
    input wire logic [1:0]  I_M_RESPONSE
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    logic [7:0] byte_ff;
    logic [7:0] nxt_byte;
    // byte fetched on the lane named by the byte enable
    always_comb begin
        nxt_byte = byte_ff;
        for (int i = 0; i < 4; i++) begin
            if (O_M_READ && !I_M_WAITREQUEST && O_M_BYTEENABLE[i]) begin
                nxt_byte = I_M_READDATA[8*i +: 8];
            end
        end
    end
    // holds it until the write goes out
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            byte_ff <= 8'h00;
        end else begin
            byte_ff <= nxt_byte;
        end
    end
    // steps of one byte move
    sequence s_rd_ok;
        O_M_READ && !I_M_WAITREQUEST && I_M_RESPONSE == RESP_OK;
    endsequence
    sequence s_rd_bad;
        O_M_READ && !I_M_WAITREQUEST && I_M_RESPONSE != RESP_OK;
    endsequence
    sequence s_wr_done;
        O_M_WRITE && !I_M_WAITREQUEST;
    endsequence
    chk_s_answer: assert property ((I_S_READ || I_S_WRITE) && O_S_WAITREQUEST
        |=> !O_S_WAITREQUEST) else $error("register answer late");
    chk_s_first: assert property ($rose(I_S_READ || I_S_WRITE) |-> O_S_WAITREQUEST)
        else $error("register answer early");
    chk_m_excl: assert property (!(O_M_READ && O_M_WRITE))
        else $error("read and write together");
    chk_m_hold: assert property ((O_M_READ || O_M_WRITE) && I_M_WAITREQUEST
        |=> (O_M_READ || O_M_WRITE) && $stable(O_M_ADDRESS) && $stable(O_M_BYTEENABLE))
        else $error("master request not held");
    chk_be_lane: assert property ((O_M_READ || O_M_WRITE) |-> $onehot(O_M_BYTEENABLE)
        && O_M_ADDRESS[1:0] == 2'b00) else $error("byte enable not one lane");
    chk_rd_wr: assert property (s_rd_ok |=> O_M_WRITE)
        else $error("no write after read");
    chk_wr_byte: assert property (O_M_WRITE |-> O_M_WRITEDATA == {4{byte_ff}})
        else $error("written byte differs from read byte");
    chk_idle_gap: assert property (s_wr_done |=> !O_M_READ && !O_M_WRITE)
        else $error("no idle cycle between bytes");
    chk_err_stop: assert property (s_rd_bad |=> !O_M_WRITE)
        else $error("write after failed read");
endmodule // mdma_top_asserts

// ==== tb/mdma_mem.sv ====
// Purpose: memory and peripheral space on the data bus
// Assumes: byte at address a holds a[7:0] xor 5a
// Notes:   reads with address bit 31 set answer with an error
`timescale 1ns/1ps
module mdma_mem (
    // bus from the engine
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_address,
    // random stall from the bench
    input  wire logic        i_stall,
    // answer
    output logic             o_waitrequest,
    output logic [31:0]      o_readdata,
    output logic [1:0]       o_response
);
    // random stall while a request stands, waitrequest held high otherwise
    assign o_waitrequest = (i_read || i_write) ? i_stall : 1'b1;
    // byte pattern per lane, inverse when not read
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            o_readdata[8*i +: 8] = (i_address[7:0] + 8'(i)) ^ 8'h5a;
        end
        if (!i_read) begin
            o_readdata = ~o_readdata;
        end
        o_response = (i_read && i_address[31]) ? 2'h2 : 2'h0;
    end
endmodule // mdma_mem

// ==== tb/multichannel_dma_controller_tb.sv ====
// Purpose: self-checking bench for the dma controller
// Assumes: memory model with random stalls on the far side
// Notes:   expected bytes follow the model's byte pattern
`timescale 1ns/1ps
module multichannel_dma_controller_tb;
    import mdma_pkg::*;
    logic         clk, rst, s_read, s_write, s_wait, m_read, m_write, m_wait, irq, stall;
    logic [15:0]  s_addr;
    logic [31:0]  s_wdata, s_rdata, m_addr, m_wdata, m_rdata, seed, src1;
    logic [3:0]   m_be;
    logic [1:0]   m_resp;
    logic [255:0] irq_in;
    logic [63:0]  e;
    logic [39:0]  w;
    int           num_errors, tests_run;
    logic [63:0]  rq[$];
    logic [39:0]  wq[$];
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    mdma_top #(.NCH(8), .NIRQ(256)) dut_u (.I_CLK(clk), .I_RST(rst), .I_S_ADDRESS(s_addr),
        .I_S_READ(s_read), .I_S_WRITE(s_write), .I_S_WRITEDATA(s_wdata),
        .I_S_BYTEENABLE(4'hf), .O_S_READDATA(s_rdata), .O_S_WAITREQUEST(s_wait),
        .O_M_ADDRESS(m_addr), .O_M_READ(m_read), .O_M_WRITE(m_write), .O_M_WRITEDATA(m_wdata),
        .O_M_BYTEENABLE(m_be), .I_M_WAITREQUEST(m_wait), .I_M_READDATA(m_rdata),
        .I_M_RESPONSE(m_resp), .I_IRQ(irq_in), .O_IRQ(irq));
    mdma_mem mem_u (.i_read(m_read), .i_write(m_write), .i_address(m_addr), .i_stall(stall),
        .o_waitrequest(m_wait), .o_readdata(m_rdata), .o_response(m_resp));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    // random stall each cycle
    always @(posedge clk) begin
        seed = xs(seed);
        stall <= seed[0];
    end
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one register access, held until waitrequest is seen low
    task automatic reg_io(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        s_addr <= a;
        s_write <= wr;
        s_read <= !wr;
        s_wdata <= d;
        @(posedge clk);
        while (s_wait !== 1'b0) @(posedge clk);
        s_read <= 1'b0;
        s_write <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [31:0] m);
        rq.push_back({m, x & m});
        reg_io(1'b0, a, 32'h0);
    endtask
    task automatic blk(input logic [31:0] src, input logic [31:0] dst, input int n);
        for (int i = 0; i < n; i++) begin
            wq.push_back({dst + 32'(i), (src[7:0] + 8'(i)) ^ 8'h5a});
        end
    endtask
    task automatic chan(input int c, input logic [31:0] src, dst, size, ctl);
        logic [15:0] b;
        b = A_CHBASE + 16'(c) * 16'h0080;
        reg_io(1'b1, b + 16'h0010, src);
        reg_io(1'b1, b + 16'h0020, dst);
        reg_io(1'b1, b + 16'h0030, size);
        reg_io(1'b1, b, ctl & 32'hffffff7f);
        reg_io(1'b1, b, ctl);
    endtask
    task automatic settle();
        wait (wq.size() == 0);
        repeat (20) @(posedge clk);
    endtask
    // compare register reads and data writes as they are accepted
    always @(posedge clk) begin
        if (s_read && s_wait === 1'b0) begin
            e = rq.pop_front();
            chk(72'(s_rdata & e[63:32]), 72'(e[31:0]));
        end
        if (m_write && m_wait === 1'b0) begin
            w = wq.pop_front();
            chk({m_addr, m_be, m_wdata}, {w[39:10], 2'b00, 4'b0001 << w[9:8], {4{w[7:0]}}});
        end
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        num_errors++;
        test_done();
    end
    initial begin
        {rst, s_read, s_write, stall} = 4'b1000;
        {s_addr, s_wdata, irq_in} = '0;
        {num_errors, tests_run} = 0;
        seed = 32'd94;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped and read-only places
        rd(A_GCTRL, 32'h0, 32'hffffffff);
        rd(A_GSTAT, 32'h0, 32'hffffffff);
        rd(A_EADDR, 32'h0, 32'hffffffff);
        rd(16'h0ffc, 32'h0, 32'hffffffff);
        reg_io(1'b1, A_GSTAT, 32'hffffffff);
        rd(A_GSTAT, 32'h0, 32'hffffffff);
        // set, invert and clear aliases
        reg_io(1'b1, A_GCTRL + A_SET, 32'h00009000);
        rd(A_GCTRL, 32'h00009000, 32'h0000d000);
        reg_io(1'b1, A_GCTRL + A_INV, 32'h00008000);
        rd(A_GCTRL, 32'h00001000, 32'h0000d000);
        reg_io(1'b1, A_GCTRL + A_CLR, 32'h00001000);
        rd(A_GCTRL + A_SET, 32'h0, 32'hffffffff);
        // two forced channels pending at once, unaligned ends
        src1 = 32'h00000300 | 32'(seed[3:0]);
        reg_io(1'b1, A_CHBASE + 16'h0050, 32'h1);
        chan(1, src1, 32'h4002, 3, 32'h81);
        chan(0, 32'h103, 32'h2001, 5, 32'h81);
        blk(32'h103, 32'h2001, 5);
        blk(src1, 32'h4002, 3);
        reg_io(1'b1, A_GCTRL + A_SET, 32'h00008000);
        settle();
        chk(72'(irq), 72'(1));
        rd(A_CHBASE + 16'h0040, 32'h1, 32'h61);
        @(posedge clk);
        chk(72'(irq), 72'(0));
        rd(A_CHBASE + 16'h0040, 32'h0, 32'h7f);
        rd(A_GSTAT, 32'h1, 32'h80000007);
        // failing source access
        chan(2, 32'h80000011, 32'h5000, 2, 32'h81);
        settle();
        rd(A_EADDR, 32'h80000011, 32'hffffffff);
        rd(A_GSTAT, 32'h80000001, 32'h80000007);
        rd(A_CHBASE + 16'h0140, 32'h40, 32'h61);
        chk(72'(irq), 72'(0));
        // interrupt-started channel chained to the next
        chan(4, 32'h600, 32'h6100, 2, 32'h5);
        chan(3, 32'h701, 32'h7003, 2, 32'h521);
        blk(32'h701, 32'h7003, 2);
        blk(32'h600, 32'h6100, 2);
        irq_in[5] <= 1'b1;
        @(posedge clk);
        irq_in[5] <= 1'b0;
        settle();
        rd(A_GSTAT, 32'h4, 32'h7);
        test_done();
    end
endmodule // multichannel_dma_controller_tb
bind mdma_top mdma_top_asserts chk_u (.I_CLK(I_CLK), .I_RST(I_RST), .I_S_READ(I_S_READ),
    .I_S_WRITE(I_S_WRITE), .O_S_WAITREQUEST(O_S_WAITREQUEST), .O_M_ADDRESS(O_M_ADDRESS),
    .O_M_READ(O_M_READ), .O_M_WRITE(O_M_WRITE), .O_M_WRITEDATA(O_M_WRITEDATA),
    .O_M_BYTEENABLE(O_M_BYTEENABLE), .I_M_WAITREQUEST(I_M_WAITREQUEST),
    .I_M_READDATA(I_M_READDATA), .I_M_RESPONSE(I_M_RESPONSE));
